// file: common/irq_seq_pkg.sv
package irq_seq_pkg;
  // ==========================================================
  // timing counts, in core clock cycles
  // ==========================================================
  localparam int unsigned ENTRY_CYCLES = 4;
  localparam int unsigned VECTOR_JUMP_CYCLES = 3;
  localparam int unsigned WAKE_EXTRA_CYCLES = 4;
  localparam int unsigned RETURN_CYCLES = 4;
  localparam logic [2:0] ENTRY_LAST = 3'h3;
  localparam logic [2:0] JUMP_LAST = 3'h2;
  localparam logic [2:0] WAKE_LAST = 3'h3;
  localparam logic [2:0] RETURN_LAST = 3'h3;

  // ==========================================================
  // register map (word offsets are byte addresses / 4)
  // ==========================================================
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h1;
  localparam logic [3:0] OFF_PIN_OFF_LOW = 4'h2;
  localparam logic [3:0] OFF_PIN_OFF_HIGH = 4'h3;
  localparam logic [3:0] OFF_STARTUP = 4'h4;
  localparam logic [3:0] OFF_WAKE_PINS = 4'h5;

  // ctrl fields
  localparam int unsigned CTRL_GIE_BIT = 0;
  localparam int unsigned CTRL_IO_STOP_BIT = 1;
  localparam int unsigned CTRL_ADC_STOP_BIT = 2;

  // reset values
  localparam logic [7:0] PIN_OFF_RESET = 8'h00;
  localparam logic [7:0] WAKE_PINS_RESET = 8'h00;
  localparam logic [7:0] STARTUP_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h04ff;
  localparam logic [15:0] VECTOR_BASE = 16'h0000;

  // ==========================================================
  // sequencer states, gray along entry path
  // ==========================================================
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STARTUP = 3'b001,
    ST_WAKE = 3'b011,
    ST_ENTRY = 3'b010,
    ST_JUMP = 3'b110,
    ST_RETURN = 3'b111
  } seq_state_t;
endpackage

// file: hdl/stall_counter.sv
`timescale 1ns/100ps
// ============================================================
// down counter used to time the sequencer startup phase
// ============================================================
module stall_counter (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [7:0] i_value,
  output logic o_zero
);
  logic [7:0] cnt_q;

  // load then count down to zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= 8'h00;
    end else if (i_load) begin
      cnt_q <= i_value;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  assign o_zero = (cnt_q == 8'h00);
endmodule

// file: hdl/irq_sequencer.sv
`timescale 1ns/100ps
module irq_sequencer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // avalon-mm slave
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // instruction sequencer side
  input wire logic i_instr_done,
  input wire logic i_instr_sei,
  input wire logic i_instr_cli,
  input wire logic i_instr_reti,
  input wire logic i_sleeping,
  input wire logic [15:0] i_pc,
  input wire logic [15:0] i_ret_pc,
  input wire logic i_irq,
  input wire logic [4:0] i_irq_num,
  input wire logic i_debug_fuse,
  output logic o_stall,
  output logic o_vec_valid,
  output logic [15:0] o_vec_addr,
  output logic o_push,
  output logic [15:0] o_push_pc,
  output logic o_resume,
  output logic [15:0] o_resume_pc,
  output logic [15:0] o_sp,
  output logic o_gie,
  output logic o_main_clk_on,
  output logic [15:0] o_pin_in_en
);
  // ==========================================================
  // declarations
  // ==========================================================
  irq_seq_pkg::seq_state_t state_q;
  logic [2:0] phase_q;
  logic gie_q;
  logic sei_shadow_q;
  logic io_stop_q;
  logic adc_stop_q;
  logic [7:0] pin_off_low_q;
  logic [7:0] pin_off_high_q;
  logic [7:0] wake_pins_q;
  logic [7:0] startup_q;
  logic [15:0] sp_q;
  logic [4:0] num_q;
  logic ack_q;
  logic start_load;
  logic start_zero;
  logic take_irq;
  logic wr_hit;
  logic rd_hit;

  function automatic logic [15:0] vector_of(input logic [4:0] n);
    vector_of = irq_seq_pkg::VECTOR_BASE + {10'h000, n, 1'b0};
  endfunction

  // ==========================================================
  // avalon slave: one wait cycle then ack
  // ==========================================================
  assign wr_hit = i_write && !ack_q;
  assign rd_hit = i_read && !ack_q;

  // ack pulses one cycle after a request is seen
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_read || i_write) && !ack_q;
    end
  end

  // waitrequest is high until the ack cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_waitrequest <= 1'b1;
    end else begin
      o_waitrequest <= !((i_read || i_write) && !ack_q);
    end
  end

  // read mux, unmapped reads zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_readdata <= 32'h0000_0000;
    end else if (rd_hit) begin
      case (i_address)
        irq_seq_pkg::OFF_CTRL:
          o_readdata <= {29'h0, adc_stop_q, io_stop_q, gie_q};
        irq_seq_pkg::OFF_STATUS:
          o_readdata <= {13'h0, state_q, sp_q};
        irq_seq_pkg::OFF_PIN_OFF_LOW:
          o_readdata <= {24'h0, pin_off_low_q};
        irq_seq_pkg::OFF_PIN_OFF_HIGH:
          o_readdata <= {24'h0, pin_off_high_q};
        irq_seq_pkg::OFF_STARTUP:
          o_readdata <= {24'h0, startup_q};
        irq_seq_pkg::OFF_WAKE_PINS:
          o_readdata <= {24'h0, wake_pins_q};
        default:
          o_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      io_stop_q <= 1'b0;
      adc_stop_q <= 1'b0;
      pin_off_low_q <= irq_seq_pkg::PIN_OFF_RESET;
      pin_off_high_q <= irq_seq_pkg::PIN_OFF_RESET;
      startup_q <= irq_seq_pkg::STARTUP_RESET;
      wake_pins_q <= irq_seq_pkg::WAKE_PINS_RESET;
    end else if (wr_hit) begin
      case (i_address)
        irq_seq_pkg::OFF_CTRL: begin
          io_stop_q <= i_writedata[irq_seq_pkg::CTRL_IO_STOP_BIT];
          adc_stop_q <= i_writedata[irq_seq_pkg::CTRL_ADC_STOP_BIT];
        end
        irq_seq_pkg::OFF_PIN_OFF_LOW: pin_off_low_q <= i_writedata[7:0];
        irq_seq_pkg::OFF_PIN_OFF_HIGH: pin_off_high_q <= i_writedata[7:0];
        irq_seq_pkg::OFF_STARTUP: startup_q <= i_writedata[7:0];
        irq_seq_pkg::OFF_WAKE_PINS: wake_pins_q <= i_writedata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // global enable and the one-instruction shadow
  // ==========================================================
  // irq taken only at an instruction boundary, never after cli
  assign take_irq = (state_q == irq_seq_pkg::ST_RUN) && i_irq && gie_q &&
    i_instr_done && !i_instr_cli &&
    !i_instr_sei && !i_instr_reti;

  // shadow marks the one instruction that runs after sei
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sei_shadow_q <= 1'b0;
    end else if (i_instr_done && i_instr_sei && !gie_q) begin
      sei_shadow_q <= 1'b1;
    end else if (i_instr_done) begin
      sei_shadow_q <= 1'b0;
    end
  end

  // enable bit: cli, sei, entry clear, return set, bus write
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gie_q <= 1'b0;
    end else if (take_irq) begin
      gie_q <= 1'b0;
    end else if (state_q == irq_seq_pkg::ST_RETURN &&
                 phase_q == irq_seq_pkg::RETURN_LAST) begin
      gie_q <= 1'b1;
    end else if (i_instr_done && i_instr_cli) begin
      gie_q <= 1'b0;
    end else if (i_instr_done && i_instr_sei) begin
      gie_q <= 1'b1;
    end else if (wr_hit && i_address == irq_seq_pkg::OFF_CTRL) begin
      gie_q <= i_writedata[irq_seq_pkg::CTRL_GIE_BIT];
    end
  end

  // ==========================================================
  // sequencer; flag word is left to software
  // ==========================================================
  assign start_load = (state_q == irq_seq_pkg::ST_RUN) && i_irq &&
    gie_q && i_sleeping;

  stall_counter u_startup (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_load(start_load),
    .i_value(startup_q),
    .o_zero(start_zero)
  );

  // state and phase counter
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= irq_seq_pkg::ST_RUN;
      phase_q <= 3'h0;
      num_q <= 5'h00;
    end else begin
      case (state_q)
        irq_seq_pkg::ST_RUN: begin
          phase_q <= 3'h0;
          if (start_load) begin
            state_q <= irq_seq_pkg::ST_STARTUP;
            num_q <= i_irq_num;
          end else if (take_irq) begin
            state_q <= irq_seq_pkg::ST_ENTRY;
            num_q <= i_irq_num;
          end else if (i_instr_reti && i_instr_done) begin
            state_q <= irq_seq_pkg::ST_RETURN;
          end
        end
        irq_seq_pkg::ST_STARTUP: begin
          if (start_zero) begin
            state_q <= irq_seq_pkg::ST_WAKE;
          end
        end
        irq_seq_pkg::ST_WAKE: begin
          phase_q <= phase_q + 3'h1;
          if (phase_q == irq_seq_pkg::WAKE_LAST) begin
            state_q <= irq_seq_pkg::ST_ENTRY;
            phase_q <= 3'h0;
          end
        end
        irq_seq_pkg::ST_ENTRY: begin
          phase_q <= phase_q + 3'h1;
          if (phase_q == irq_seq_pkg::ENTRY_LAST) begin
            state_q <= irq_seq_pkg::ST_JUMP;
            phase_q <= 3'h0;
          end
        end
        irq_seq_pkg::ST_JUMP: begin
          phase_q <= phase_q + 3'h1;
          if (phase_q == irq_seq_pkg::JUMP_LAST) begin
            state_q <= irq_seq_pkg::ST_RUN;
            phase_q <= 3'h0;
          end
        end
        irq_seq_pkg::ST_RETURN: begin
          phase_q <= phase_q + 3'h1;
          if (phase_q == irq_seq_pkg::RETURN_LAST) begin
            state_q <= irq_seq_pkg::ST_RUN;
            phase_q <= 3'h0;
          end
        end
        default: begin
          state_q <= irq_seq_pkg::ST_RUN;
          phase_q <= 3'h0;
        end
      endcase
    end
  end

  // stack pointer: two bytes down on push, up on pop
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sp_q <= irq_seq_pkg::SP_RESET;
    end else if (state_q == irq_seq_pkg::ST_ENTRY && phase_q == 3'h0) begin
      sp_q <= sp_q - 16'h0002;
    end else if (state_q == irq_seq_pkg::ST_RETURN &&
                 phase_q == irq_seq_pkg::RETURN_LAST) begin
      sp_q <= sp_q + 16'h0002;
    end
  end

  // ==========================================================
  // registered outputs to the instruction sequencer
  // ==========================================================
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_stall <= 1'b0;
      o_push <= 1'b0;
      o_push_pc <= 16'h0000;
      o_vec_valid <= 1'b0;
      o_vec_addr <= 16'h0000;
      o_resume <= 1'b0;
      o_resume_pc <= 16'h0000;
      o_sp <= irq_seq_pkg::SP_RESET;
      o_gie <= 1'b0;
    end else begin
      o_stall <= (state_q != irq_seq_pkg::ST_RUN) || take_irq || start_load;
      o_push <= take_irq;
      if (take_irq) begin
        o_push_pc <= i_pc;
      end
      o_vec_valid <= (state_q == irq_seq_pkg::ST_ENTRY &&
        phase_q == irq_seq_pkg::ENTRY_LAST);
      o_vec_addr <= vector_of(num_q);
      o_resume <= (state_q == irq_seq_pkg::ST_RETURN &&
        phase_q == irq_seq_pkg::RETURN_LAST);
      o_resume_pc <= i_ret_pc;
      o_sp <= sp_q;
      o_gie <= gie_q;
    end
  end

  // ==========================================================
  // sleep: pin buffers and debug clock
  // ==========================================================
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pin_in_en <= 16'hffff;
      o_main_clk_on <= 1'b1;
    end else begin
      if (i_sleeping && io_stop_q && adc_stop_q) begin
        o_pin_in_en <= {8'h00, wake_pins_q};
      end else begin
        o_pin_in_en <= ~{pin_off_high_q, pin_off_low_q};
      end
      o_main_clk_on <= !i_sleeping || i_debug_fuse;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  sequence s_entry_start;
    take_irq;
  endsequence

  sequence s_vector_out;
    ##5 o_vec_valid;
  endsequence

  chk_entry_latency: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_entry_start |-> s_vector_out)
    else $error("vector not issued after the four entry cycles");

  chk_cli_blocks: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_instr_done && i_instr_cli) |-> !take_irq)
    else $error("irq taken on disable instruction");

  chk_sei_shadow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (sei_shadow_q && i_instr_done && i_irq && gie_q && !i_instr_cli &&
     !i_instr_reti && !i_instr_sei && state_q == irq_seq_pkg::ST_RUN) |->
      take_irq)
    else $error("irq not taken after the instruction following enable");

  chk_push_pc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    take_irq |=> (o_push && o_push_pc == $past(i_pc)))
    else $error("program counter not pushed");

  chk_jump_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(state_q == irq_seq_pkg::ST_JUMP) |->
      (state_q == irq_seq_pkg::ST_JUMP)[*3] ##1
      (state_q == irq_seq_pkg::ST_RUN))
    else $error("vector jump not three cycles");

  chk_multi_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == irq_seq_pkg::ST_RUN && !i_instr_done) |=>
      state_q != irq_seq_pkg::ST_ENTRY)
    else $error("entry began mid instruction");

  chk_wake_extra: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(state_q == irq_seq_pkg::ST_WAKE) |->
      (state_q == irq_seq_pkg::ST_WAKE)[*4] ##1
      (state_q == irq_seq_pkg::ST_ENTRY))
    else $error("wake adds wrong cycles");

  chk_return_pop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_instr_reti && i_instr_done && state_q == irq_seq_pkg::ST_RUN &&
     !take_irq && !start_load) |-> ##5 (gie_q &&
      sp_q == $past(sp_q, 5) + 16'h0002 && o_resume))
    else $error("return sequence wrong");

  chk_entry_gie: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    take_irq |=> !gie_q)
    else $error("enable not cleared on entry");

  chk_debug_clk: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_debug_fuse |=> o_main_clk_on)
    else $error("main clock stopped with debug on");
endmodule

// file: tb/core_model.sv
`timescale 1ns/100ps
// ==========================================================
// core model: runs queued instructions, one-level stack
// ==========================================================
module core_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_stall,
  input wire logic i_push,
  input wire logic [15:0] i_push_pc,
  input wire logic i_resume,
  input wire logic [15:0] i_resume_pc,
  output logic o_done,
  output logic o_sei,
  output logic o_cli,
  output logic o_reti,
  output logic [15:0] o_pc,
  output logic [15:0] o_ret_pc
);
  logic [5:0] q[$];
  logic [5:0] cur;
  logic [3:0] cnt_q;
  logic [1:0] kind_q;

  // queue one instruction: kind 0 plain, 1 enable, 2 disable, 3 return
  task automatic issue(input logic [1:0] k, input logic [3:0] len);
    q.push_back({k, len});
  endtask

  // fetch, count down, retire; flag word never stacked here
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    o_sei <= 1'b0;
    o_cli <= 1'b0;
    o_reti <= 1'b0;
    if (!i_rst_n) begin
      cnt_q <= 4'h0;
      o_pc <= 16'h0100;
      o_ret_pc <= 16'hffff;
    end else begin
      if (i_push) begin
        o_ret_pc <= i_push_pc;
      end
      if (i_resume) begin
        o_pc <= i_resume_pc;
      end else if (i_stall !== 1'b1) begin
        if (cnt_q == 4'h0 && q.size() > 0) begin
          cur = q.pop_front();
          cnt_q <= cur[3:0];
          kind_q <= cur[5:4];
        end else if (cnt_q == 4'h1) begin
          o_done <= 1'b1;
          o_sei <= (kind_q == 2'h1);
          o_cli <= (kind_q == 2'h2);
          o_reti <= (kind_q == 2'h3);
          o_pc <= o_pc + 16'h0001;
          cnt_q <= 4'h0;
        end else if (cnt_q > 4'h1) begin
          cnt_q <= cnt_q - 4'h1;
        end
      end
    end
  end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; \
  if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
// ==========================================================
// bench top
// ==========================================================
module tb_top;
  logic clk, rst_n, bus_rd, bus_wr, bus_wait, sleeping, irq, debug_fuse;
  logic [3:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata, v;
  logic [4:0] irq_num;
  logic done, sei, cli, reti, stall, vec_valid, push, resume, gie, clk_on;
  logic [15:0] pc, ret_pc, vec_addr, push_pc, resume_pc, sp, pin_en, sv_pc;
  logic irq_prev;
  int fails, checks, cyc, n_push, n_vec, n_res, n_done, n_stall;
  int t_push, t_vec, t_res, t_done, t_irq, d_at_push, base, lat, n;

  irq_sequencer irq_sequencer_i (.i_clk(clk), .i_rst_n(rst_n),
    .i_address(bus_addr), .i_read(bus_rd), .i_write(bus_wr),
    .i_writedata(bus_wdata), .o_readdata(bus_rdata),
    .o_waitrequest(bus_wait), .i_instr_done(done), .i_instr_sei(sei),
    .i_instr_cli(cli), .i_instr_reti(reti), .i_sleeping(sleeping),
    .i_pc(pc), .i_ret_pc(ret_pc), .i_irq(irq), .i_irq_num(irq_num),
    .i_debug_fuse(debug_fuse), .o_stall(stall), .o_vec_valid(vec_valid),
    .o_vec_addr(vec_addr), .o_push(push), .o_push_pc(push_pc),
    .o_resume(resume), .o_resume_pc(resume_pc), .o_sp(sp), .o_gie(gie),
    .o_main_clk_on(clk_on), .o_pin_in_en(pin_en));

  core_model core_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_stall(stall),
    .i_push(push), .i_push_pc(push_pc), .i_resume(resume),
    .i_resume_pc(resume_pc), .o_done(done), .o_sei(sei), .o_cli(cli),
    .o_reti(reti), .o_pc(pc), .o_ret_pc(ret_pc));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // event counters and time stamps
  always @(posedge clk) begin
    cyc <= cyc + 1;
    irq_prev <= irq;
    if (irq === 1'b1 && irq_prev !== 1'b1) t_irq <= cyc;
    if (stall === 1'b1) n_stall <= n_stall + 1;
    if (done === 1'b1) begin
      t_done <= cyc;
      n_done <= n_done + 1;
    end
    if (push === 1'b1) begin
      t_push <= cyc;
      n_push <= n_push + 1;
      d_at_push <= n_done;
    end
    if (vec_valid === 1'b1) begin
      t_vec <= cyc;
      n_vec <= n_vec + 1;
    end
    if (resume === 1'b1) begin
      t_res <= cyc;
      n_res <= n_res + 1;
    end
  end

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one avalon access, held until waitrequest sampled low
  task automatic bus(input logic [3:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    bus_addr <= a;
    bus_wr <= w;
    bus_rd <= ~w;
    bus_wdata <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (bus_wait !== 1'b0 && k < 50);
    q = bus_rdata;
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
    @(posedge clk);
    if (k >= 50) begin
      fails++;
      test_done();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e,
                       input string nm);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    `CHK(nm, e, q)
  endtask

  function automatic int evt(input int s);
    case (s)
      0: return n_push;
      1: return n_vec;
      2: return n_res;
      default: return n_done;
    endcase
  endfunction

  // bounded wait for an event count
  task automatic wait_evt(input int s, input int tgt);
    int k;
    k = 0;
    while (evt(s) < tgt && k < 300) begin
      @(posedge clk);
      k++;
    end
    if (k >= 300) begin
      fails++;
      $display("wrong value wait %0d exp %0d got %0d", s, tgt, evt(s));
      test_done();
    end
  endtask

  // main sequence
  initial begin
    {rst_n, bus_rd, bus_wr, sleeping, irq, debug_fuse} = 6'h00;
    {bus_addr, bus_wdata, irq_num} = '0;
    {cyc, n_push, n_vec, n_res, n_done, n_stall, fails, checks} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("sp", irq_seq_pkg::SP_RESET, sp)
    `CHK("pin_en", 16'hffff, pin_en)
    rdchk(irq_seq_pkg::OFF_CTRL, 32'h0, "ctrl");
    rdchk(4'hf, 32'h0, "unmapped");
    wr(irq_seq_pkg::OFF_PIN_OFF_LOW, 32'h0f);
    wr(irq_seq_pkg::OFF_PIN_OFF_HIGH, 32'h80);
    `CHK("pin_en", 16'h7ff0, pin_en)
    rdchk(irq_seq_pkg::OFF_PIN_OFF_LOW, 32'h0f, "pin_off");
    wr(irq_seq_pkg::OFF_PIN_OFF_LOW, 32'h0);
    wr(irq_seq_pkg::OFF_PIN_OFF_HIGH, 32'h0);
    // deep sleep input gating, debug clock
    wr(irq_seq_pkg::OFF_WAKE_PINS, 32'h03);
    sleeping <= 1'b1;
    debug_fuse <= 1'b1;
    wr(irq_seq_pkg::OFF_CTRL, 32'h2);
    `CHK("pin_en io", 16'hffff, pin_en)
    wr(irq_seq_pkg::OFF_CTRL, 32'h6);
    `CHK("pin_en deep", 16'h0003, pin_en)
    `CHK("clk_on", 1'b1, clk_on)
    sleeping <= 1'b0;
    wr(irq_seq_pkg::OFF_CTRL, 32'h1);
    // entry after a multi-cycle instruction
    base = n_stall;
    irq_num <= 5'h05;
    irq <= 1'b1;
    core_model_i.issue(2'h0, 4'h3);
    wait_evt(0, n_push + 1);
    irq <= 1'b0;
    sv_pc = 16'h0100 + 16'(n_done);
    `CHK("push gap", 1, t_push - t_done)
    `CHK("push_pc", sv_pc, push_pc)
    `CHK("gie entry", 1'b0, gie)
    wait_evt(1, n_vec + 1);
    `CHK("vec gap", 4, t_vec - t_push)
    `CHK("vec", 16'h000a, vec_addr)
    repeat (6) @(posedge clk);
    `CHK("stall", 8, n_stall - base)
    `CHK("sp push", 16'h04fd, sp)
    // return
    core_model_i.issue(2'h3, 4'h1);
    wait_evt(2, n_res + 1);
    `CHK("ret time", 5, t_res - t_done)
    `CHK("ret pc", sv_pc, resume_pc)
    `CHK("sp pop", 16'h04ff, sp)
    `CHK("gie ret", 1'b1, gie)
    // disable with request in the same cycle
    base = n_push;
    irq <= 1'b1;
    core_model_i.issue(2'h2, 4'h1);
    core_model_i.issue(2'h0, 4'h1);
    wait_evt(3, n_done + 2);
    repeat (8) @(posedge clk);
    `CHK("no entry", base, n_push)
    `CHK("gie cli", 1'b0, gie)
    // enable lets one instruction through first
    base = n_done;
    core_model_i.issue(2'h1, 4'h1);
    core_model_i.issue(2'h0, 4'h1);
    core_model_i.issue(2'h0, 4'h1);
    wait_evt(0, n_push + 1);
    irq <= 1'b0;
    `CHK("sei count", 2, d_at_push - base)
    `CHK("sei gap", 1, t_push - t_done)
    wait_evt(1, n_vec + 1);
    repeat (4) @(posedge clk);
    core_model_i.issue(2'h3, 4'h1);
    wait_evt(2, n_res + 1);
    // wake from sleep
    wr(irq_seq_pkg::OFF_STARTUP, 32'h05);
    sleeping <= 1'b1;
    irq_num <= 5'h02;
    irq <= 1'b1;
    n = 0;
    while (stall !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    sleeping <= 1'b0;
    wait_evt(1, n_vec + 1);
    irq <= 1'b0;
    lat = t_vec - t_irq;
    `CHK("wake lat", 1'b1, lat >= 13 && lat <= 16)
    `CHK("wake vec", 16'h0004, vec_addr)
    test_done();
  end
endmodule
